/* lsrc_consts.svh */
// register offsets, field positions, reset values and counts of the light sensor block
`ifndef LSRC_CONSTS_SVH
`define LSRC_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define LSRC_REG_OPERATION 3'h0
`define LSRC_REG_ALARM 3'h1
`define LSRC_REG_THR_UPPER 3'h2
`define LSRC_REG_THR_LOWER 3'h3
`define LSRC_REG_READ_LO 3'h4
`define LSRC_REG_READ_HI 3'h5
`define LSRC_REG_COUNT_LO 3'h6
`define LSRC_REG_COUNT_HI 3'h7

// ----------------------------------------------------------------
// address byte command bits
// ----------------------------------------------------------------
`define LSRC_ADDR_RESTART_BIT 7
`define LSRC_ADDR_CLEAR_BIT 6
`define LSRC_ADDR_SEL_HI 2

// ----------------------------------------------------------------
// operation_config fields
// ----------------------------------------------------------------
`define LSRC_OP_ENABLE_BIT 7
`define LSRC_OP_PD_BIT 6
`define LSRC_OP_TIMING_BIT 5
`define LSRC_OP_RSVD_BIT 4
`define LSRC_OP_DIODE_HI 3
`define LSRC_OP_DIODE_LO 2
`define LSRC_OP_WIDTH_HI 1
`define LSRC_OP_WIDTH_LO 0

// ----------------------------------------------------------------
// alarm_range_config fields
// ----------------------------------------------------------------
`define LSRC_AL_FLAG_BIT 5
`define LSRC_AL_RANGE_HI 3
`define LSRC_AL_RANGE_LO 2
`define LSRC_AL_PERSIST_HI 1
`define LSRC_AL_PERSIST_LO 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LSRC_RST_OPERATION 8'h00
`define LSRC_RST_ALARM 8'h00
`define LSRC_RST_THR_UPPER 8'hFF
`define LSRC_RST_THR_LOWER 8'h00
`define LSRC_THR_LOW_BYTE 8'h00

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define LSRC_EXP_W0 5'h10
`define LSRC_EXP_W1 5'h0C
`define LSRC_EXP_W2 5'h08
`define LSRC_EXP_W3 5'h04
`define LSRC_PERSIST_P0 5'h01
`define LSRC_PERSIST_P1 5'h04
`define LSRC_PERSIST_P2 5'h08
`define LSRC_PERSIST_P3 5'h10
// oscillator rates in kHz, slow for ranges 0/1, fast for ranges 2/3
`define LSRC_OSC_SLOW_KHZ 16'h0147
`define LSRC_OSC_FAST_KHZ 16'h028F

`endif

/* lsrc_pkg.sv */
// types shared by the light sensor register and control block
package lsrc_pkg;

  // conversion sequencer states, gray along idle, phase a, phase b, load
  typedef enum logic [1:0] {
    lsrc_st_idle = 2'b00,
    lsrc_st_phase_a = 2'b01,
    lsrc_st_phase_b = 2'b11,
    lsrc_st_load = 2'b10
  } lsrc_state_t;

  // photodiode input selection
  typedef enum logic [1:0] {
    broadband_only_select = 2'b00,
    infrared_only_select = 2'b01,
    difference_select = 2'b10,
    lsrc_diode_none = 2'b11
  } lsrc_diode_t;

endpackage

/* lsrc_sync_edge.sv */
// two flop synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none

module lsrc_sync_edge (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ----------------------------------------------------------------
  // synchroniser and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (clk_en_in) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~last_q;

endmodule

`default_nettype wire

/* lsrc_core.sv */
// register set and conversion control of the light sensor block
`timescale 1ns/1ps
`default_nettype none
`include "lsrc_consts.svh"

module lsrc_core #(
  parameter int DATA_W = 16,
  parameter int CYC_W = 17
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic osc_clk_in,
  input wire logic broadband_photodiode_in,
  input wire logic infrared_photodiode_in,
  output logic [7:0] rd_data_out,
  output logic int_pin_out,
  output logic int_pin_oe_out,
  output logic core_reset_out,
  output logic converter_power_down_out,
  output logic osc_fast_sel_out,
  output logic [1:0] range_sel_out,
  output var lsrc_pkg::lsrc_diode_t diode_sel_out,
  output logic integrating_out
);

  import lsrc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] op_q;
  logic [7:0] alarm_q;
  logic [7:0] thr_upper_q;
  logic [7:0] thr_lower_q;
  logic flag_q;
  logic [DATA_W-1:0] reading_q;
  logic [DATA_W-1:0] period_count_q;
  lsrc_state_t st_q;
  logic [CYC_W-1:0] cyc_q;
  logic [DATA_W-1:0] bb_cnt_q;
  logic [DATA_W-1:0] ir_cnt_q;
  logic [DATA_W-1:0] tmr_cnt_q;
  logic [4:0] persist_q;
  logic [7:0] rd_data_q;
  logic core_reset_q;
  logic power_down_q;
  logic osc_fast_q;
  logic [1:0] range_q;
  lsrc_diode_t diode_q;
  logic integrating_q;
  logic osc_tick;
  logic bb_rise;
  logic ir_rise;
  logic wr;
  logic data_wr;
  logic restart_cmd;
  logic clear_cmd;
  logic [2:0] sel;
  lsrc_diode_t diode;
  logic ext_mode;
  logic core_run;
  logic running;
  logic [CYC_W-1:0] period;
  logic [DATA_W-1:0] cnt_max;
  logic phase_end;
  logic abort;
  logic restart_cnt;
  logic bb_en;
  logic ir_en;
  logic [DATA_W-1:0] reading_d;
  logic [DATA_W-1:0] thr_upper_full;
  logic [DATA_W-1:0] thr_lower_full;
  logic out_of_window;
  logic [4:0] persist_need;
  logic alarm_hit;
  logic flag_clear;

  function automatic logic [4:0] width_exp(input logic [1:0] code);
    case (code)
      2'b00: width_exp = `LSRC_EXP_W0;
      2'b01: width_exp = `LSRC_EXP_W1;
      2'b10: width_exp = `LSRC_EXP_W2;
      default: width_exp = `LSRC_EXP_W3;
    endcase
  endfunction

  function automatic logic [4:0] persist_count(input logic [1:0] code);
    case (code)
      2'b00: persist_count = `LSRC_PERSIST_P0;
      2'b01: persist_count = `LSRC_PERSIST_P1;
      2'b10: persist_count = `LSRC_PERSIST_P2;
      default: persist_count = `LSRC_PERSIST_P3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  lsrc_sync_edge u_sync_osc (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .async_in(osc_clk_in),
    .level_out(),
    .rise_out(osc_tick)
  );

  lsrc_sync_edge u_sync_bb (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .async_in(broadband_photodiode_in),
    .level_out(),
    .rise_out(bb_rise)
  );

  lsrc_sync_edge u_sync_ir (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .async_in(infrared_photodiode_in),
    .level_out(),
    .rise_out(ir_rise)
  );

  // ----------------------------------------------------------------
  // write decode and address commands
  // ----------------------------------------------------------------
  assign wr = reg_wr_in & clk_en_in;
  assign sel = reg_addr_in[`LSRC_ADDR_SEL_HI:0];
  assign data_wr = wr & (reg_addr_in[7:3] == 5'h00);
  assign restart_cmd = wr & reg_addr_in[`LSRC_ADDR_RESTART_BIT];
  assign clear_cmd = wr & reg_addr_in[`LSRC_ADDR_CLEAR_BIT];

  // ----------------------------------------------------------------
  // operating settings
  // ----------------------------------------------------------------
  // diode selection code
  assign diode = lsrc_diode_t'(op_q[`LSRC_OP_DIODE_HI:`LSRC_OP_DIODE_LO]);
  assign ext_mode = op_q[`LSRC_OP_TIMING_BIT];
  assign core_run = op_q[`LSRC_OP_ENABLE_BIT] & ~op_q[`LSRC_OP_PD_BIT]
                    & (diode != lsrc_diode_none);
  assign running = (st_q == lsrc_st_phase_a) | (st_q == lsrc_st_phase_b);
  assign period = CYC_W'({{(CYC_W-1){1'b0}}, 1'b1} << width_exp(op_q[1:0]));
  assign cnt_max = (diode == difference_select) ? DATA_W'((period >> 1) - 1'b1)
                                                : DATA_W'(period - 1'b1);
  assign phase_end = running & (ext_mode ? restart_cmd
                                         : (osc_tick & (cyc_q == period - 1'b1)));
  assign abort = running & ~ext_mode & restart_cmd;
  assign restart_cnt = (st_q == lsrc_st_idle) | (st_q == lsrc_st_load) | abort;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      st_q <= lsrc_st_idle;
    end else if (clk_en_in) begin
      if (!core_run) begin
        st_q <= lsrc_st_idle;
      end else begin
        case (st_q)
          lsrc_st_idle: begin
            st_q <= lsrc_st_phase_a;
          end
          lsrc_st_phase_a: begin
            if (abort) begin
              st_q <= lsrc_st_phase_a;
            end else if (phase_end) begin
              if (diode == difference_select && !ext_mode) begin
                st_q <= lsrc_st_phase_b;
              end else begin
                st_q <= lsrc_st_load;
              end
            end
          end
          lsrc_st_phase_b: begin
            if (abort) begin
              st_q <= lsrc_st_phase_a;
            end else if (phase_end) begin
              st_q <= lsrc_st_load;
            end
          end
          lsrc_st_load: begin
            st_q <= lsrc_st_phase_a;
          end
          default: begin
            st_q <= lsrc_st_idle;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillator cycle counter of the current phase
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cyc_q <= '0;
    end else if (clk_en_in) begin
      if (restart_cnt || phase_end || !core_run) begin
        cyc_q <= '0;
      end else if (osc_tick && running) begin
        cyc_q <= cyc_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // charge count registers
  // ----------------------------------------------------------------
  assign bb_en = (st_q == lsrc_st_phase_a) & (diode != infrared_only_select);
  assign ir_en = ((st_q == lsrc_st_phase_a) & ((diode == infrared_only_select)
                 | ((diode == difference_select) & ext_mode)))
                 | (st_q == lsrc_st_phase_b);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      bb_cnt_q <= '0;
      ir_cnt_q <= '0;
    end else if (clk_en_in) begin
      if (restart_cnt || !core_run) begin
        bb_cnt_q <= '0;
        ir_cnt_q <= '0;
      end else begin
        if (bb_en && bb_rise && bb_cnt_q < cnt_max) begin
          bb_cnt_q <= bb_cnt_q + 1'b1;
        end
        if (ir_en && ir_rise && ir_cnt_q < cnt_max) begin
          ir_cnt_q <= ir_cnt_q + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // integration timer
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tmr_cnt_q <= '0;
    end else if (clk_en_in) begin
      if (restart_cnt || !core_run) begin
        tmr_cnt_q <= '0;
      end else if (osc_tick && running && tmr_cnt_q != {DATA_W{1'b1}}) begin
        tmr_cnt_q <= tmr_cnt_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // result capture
  // ----------------------------------------------------------------
  always_comb begin
    case (diode)
      infrared_only_select: reading_d = ir_cnt_q;
      difference_select: reading_d = bb_cnt_q - ir_cnt_q;
      default: reading_d = bb_cnt_q;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      reading_q <= '0;
      period_count_q <= '0;
    end else if (clk_en_in) begin
      if (st_q == lsrc_st_load) begin
        reading_q <= reading_d;
        period_count_q <= tmr_cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // threshold alarm
  // ----------------------------------------------------------------
  // threshold low byte zero
  assign thr_upper_full = {thr_upper_q, `LSRC_THR_LOW_BYTE};
  assign thr_lower_full = {thr_lower_q, `LSRC_THR_LOW_BYTE};
  assign out_of_window = (reading_d > thr_upper_full) | (reading_d < thr_lower_full);
  assign persist_need = persist_count(alarm_q[`LSRC_AL_PERSIST_HI:`LSRC_AL_PERSIST_LO]);
  assign alarm_hit = (st_q == lsrc_st_load) & out_of_window
                     & ((persist_q + 5'h01) >= persist_need);
  assign flag_clear = clear_cmd | (data_wr & (sel == `LSRC_REG_ALARM)
                      & ~reg_wdata_in[`LSRC_AL_FLAG_BIT]);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      persist_q <= '0;
    end else if (clk_en_in) begin
      if (!core_run) begin
        persist_q <= '0;
      end else if (st_q == lsrc_st_load) begin
        if (!out_of_window) begin
          persist_q <= '0;
        end else if (persist_q < persist_need) begin
          persist_q <= persist_q + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (alarm_hit) begin
        flag_q <= 1'b1;
      end else if (flag_clear) begin
        flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      op_q <= `LSRC_RST_OPERATION;
      alarm_q <= `LSRC_RST_ALARM;
      thr_upper_q <= `LSRC_RST_THR_UPPER;
      thr_lower_q <= `LSRC_RST_THR_LOWER;
    end else if (data_wr) begin
      case (sel)
        `LSRC_REG_OPERATION: begin
          op_q <= reg_wdata_in & ~(8'h01 << `LSRC_OP_RSVD_BIT);
        end
        `LSRC_REG_ALARM: begin
          alarm_q <= reg_wdata_in & ~(8'h01 << `LSRC_AL_FLAG_BIT);
        end
        `LSRC_REG_THR_UPPER: begin
          thr_upper_q <= reg_wdata_in;
        end
        `LSRC_REG_THR_LOWER: begin
          thr_lower_q <= reg_wdata_in;
        end
        default: begin
          op_q <= op_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_data_q <= 8'h00;
    end else if (clk_en_in) begin
      case (sel)
        `LSRC_REG_OPERATION: rd_data_q <= op_q;
        `LSRC_REG_ALARM: rd_data_q <= alarm_q | {2'b00, flag_q, 5'h00};
        `LSRC_REG_THR_UPPER: rd_data_q <= thr_upper_q;
        `LSRC_REG_THR_LOWER: rd_data_q <= thr_lower_q;
        `LSRC_REG_READ_LO: rd_data_q <= reading_q[7:0];
        `LSRC_REG_READ_HI: rd_data_q <= reading_q[15:8];
        `LSRC_REG_COUNT_LO: rd_data_q <= period_count_q[7:0];
        `LSRC_REG_COUNT_HI: rd_data_q <= period_count_q[15:8];
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog side controls
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      core_reset_q <= 1'b1;
      power_down_q <= 1'b0;
      osc_fast_q <= 1'b0;
      range_q <= 2'b00;
      diode_q <= broadband_only_select;
      integrating_q <= 1'b0;
    end else if (clk_en_in) begin
      core_reset_q <= ~op_q[`LSRC_OP_ENABLE_BIT];
      power_down_q <= op_q[`LSRC_OP_PD_BIT];
      osc_fast_q <= alarm_q[`LSRC_AL_RANGE_HI];
      range_q <= alarm_q[`LSRC_AL_RANGE_HI:`LSRC_AL_RANGE_LO];
      if (st_q == lsrc_st_phase_b) begin
        diode_q <= infrared_only_select;
      end else begin
        diode_q <= diode;
      end
      integrating_q <= running;
    end
  end

  assign rd_data_out = rd_data_q;
  assign int_pin_out = 1'b0;
  assign int_pin_oe_out = flag_q;
  assign core_reset_out = core_reset_q;
  assign converter_power_down_out = power_down_q;
  assign osc_fast_sel_out = osc_fast_q;
  assign range_sel_out = range_q;
  assign diode_sel_out = diode_q;
  assign integrating_out = integrating_q;

endmodule

`default_nettype wire

/* lsrc_core_sva.sv */
// assertions on the light sensor control ports
`timescale 1ns/1ps
`default_nettype none
module lsrc_core_sva (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] rd_data_out,
  input wire logic int_pin_oe_out,
  input wire logic core_reset_out,
  input wire logic converter_power_down_out,
  input wire logic osc_fast_sel_out,
  input wire logic [1:0] range_sel_out,
  input wire logic integrating_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // write steps
  // ----------------------------------------------------------------
  sequence s_wr(a);
    reg_wr_in && clk_en_in && reg_addr_in == a ##1 clk_en_in;
  endsequence
  sequence s_clr;
    reg_wr_in && clk_en_in && integrating_out
      && (reg_addr_in[6] || reg_addr_in == 8'h01 && !reg_wdata_in[5]) ##1 integrating_out;
  endsequence
  property p_enable;
    s_wr(8'h00) |=> core_reset_out == !$past(reg_wdata_in[7], 2);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not followed");
  property p_halt;
    core_reset_out && $past(core_reset_out) |-> !integrating_out;
  endproperty
  a_halt: assert property (p_halt) else $error("integrating while held");
  property p_pdown;
    s_wr(8'h00) |=> converter_power_down_out == $past(reg_wdata_in[6], 2);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power down bit not followed");
  property p_range;
    s_wr(8'h01) |=> range_sel_out == $past(reg_wdata_in[3:2], 2)
      && osc_fast_sel_out == $past(reg_wdata_in[3], 2);
  endproperty
  a_range: assert property (p_range) else $error("range select wrong");
  property p_thr;
    s_wr(8'h02) ##0 reg_addr_in[2:0] == 3'h2 |=> rd_data_out == $past(reg_wdata_in, 2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  property p_clear;
    s_clr |-> !int_pin_oe_out;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_flag;
    clk_en_in && reg_addr_in[2:0] == 3'h1 |=> rd_data_out[5] == $past(int_pin_oe_out);
  endproperty
  a_flag: assert property (p_flag) else $error("flag bit differs from pin");
  property p_rsvd;
    clk_en_in && reg_addr_in[2:0] == 3'h0 |=> !rd_data_out[4];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
endmodule
`default_nettype wire

/* lsrc_host_model.sv */
// host model issuing register writes, reads and address commands
`timescale 1ns/1ps
`default_nettype none
module lsrc_host_model (
  input wire logic clock_in,
  input wire logic [7:0] rd_data_in,
  output logic reg_wr_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = (a[2:0] == 3'h1) ? d & 8'h2F : d;
    @(posedge clock_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~reg_wdata_out;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_addr_out = a;
    @(posedge clock_in);
    #1;
    d = rd_data_in;
  endtask
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench of the light sensor register and control block
`timescale 1ns/1ps
`default_nettype none
`include "lsrc_consts.svh"
module tb;
  logic clock_in, sys_rst_in, clk_en_in, osc, bb_t, bb_en, ir_en;
  logic reg_wr, int_pin, int_oe, core_rst, pd, fast, integ;
  logic [7:0] addr, wdata, rd_data, b;
  logic [1:0] range;
  lsrc_pkg::lsrc_diode_t dsel;
  logic [15:0] v, e;
  logic [31:0] r, x;
  int bad_count, n_checks, cyc, i, j, t0;
  logic [7:0] rv[4] = '{`LSRC_RST_OPERATION, `LSRC_RST_ALARM, `LSRC_RST_THR_UPPER,
    `LSRC_RST_THR_LOWER};
  logic [7:0] mw[4] = '{8'h02, 8'h07, 8'h0B, 8'h03};
  int pc[4] = '{1, 4, 8, 16};
  lsrc_core u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .osc_clk_in(osc),
    .broadband_photodiode_in(bb_t & bb_en), .infrared_photodiode_in(bb_t & ir_en),
    .rd_data_out(rd_data), .int_pin_out(int_pin), .int_pin_oe_out(int_oe),
    .core_reset_out(core_rst), .converter_power_down_out(pd), .osc_fast_sel_out(fast),
    .range_sel_out(range), .diode_sel_out(dsel), .integrating_out(integ));
  lsrc_host_model u_host (.clock_in(clock_in), .rd_data_in(rd_data), .reg_wr_out(reg_wr),
    .reg_addr_out(addr), .reg_wdata_out(wdata));
  // ----------------------------------------------------------------
  // clocks, stimulus and helpers
  // ----------------------------------------------------------------
  initial begin
    clock_in = 0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    osc = 0;
    #7;
    forever #80 osc = ~osc;
  end
  initial begin
    bb_t = 0;
    forever #25 bb_t = ~bb_t;
  end
  always @(posedge clock_in) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected timer and reading of one internal conversion
  function automatic logic [31:0] expv(input logic [7:0] m);
    logic [15:0] n;
    n = 16'h1 << (16 - 4 * m[1:0]);
    return {m[3] ? n << 1 : n, m[3] ? (n >> 1) - 16'h1 : (m[2] ? 16'h0 : n - 16'h1)};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] ex, input string s);
    n_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("BAD %0t %s: %h vs %h", $time, s, got, ex);
    end
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] q);
    u_host.rd(a, q[7:0]);
    u_host.rd(a + 8'h1, q[15:8]);
  endtask
  task automatic wait_load();
    int k;
    logic p;
    p = 1'b0;
    for (k = 0; k < 6000 && !(p && !integ); k++) begin
      p = integ;
      @(posedge clock_in);
      #2;
    end
    if (k >= 6000) chk(1, 0, "no conversion");
    repeat (3) @(posedge clock_in);
  endtask
  task automatic test_done();
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // about 10k cycles expected, cut at 50k
  initial begin
    #1_000_000;
    chk(1, 0, "watchdog");
    test_done();
  end
  initial begin
    sys_rst_in = 1;
    clk_en_in = 1;
    bb_en = 0;
    ir_en = 0;
    r = 32'h165385F0;
    repeat (12) @(posedge clock_in);
    #1 sys_rst_in = 0;
    chk({core_rst, pd}, 2, "enable and power down");
    for (i = 0; i < 4; i++) begin
      u_host.rd(8'(i), b);
      chk(b, rv[i], "reset value");
    end
    u_host.wr(8'h04, 8'hA5);
    rd16(8'h04, v);
    chk(v, 0, "read-only write");
    for (i = 0; i < 6; i++) begin
      r = lfsr(r);
      u_host.wr(8'(2 + i % 2), r[7:0]);
      u_host.rd(8'(2 + i % 2), b);
      chk(b, r[7:0], "threshold");
    end
    clk_en_in = 0;
    u_host.wr(8'h03, ~r[7:0]);
    clk_en_in = 1;
    u_host.rd(8'h03, b);
    chk(b, r[7:0], "frozen write");
    u_host.wr(8'h00, 8'h50);
    u_host.rd(8'h00, b);
    chk({b, 7'h0, pd}, 16'h4001, "op write");
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h01, 8'(i * 4));
      u_host.rd(8'h01, b);
      chk({b, range, fast}, {8'(i * 4), 2'(i), 1'(i / 2)}, "range");
    end
    $display("test registers done");
    bb_en = 1;
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h00, 8'h00);
      u_host.wr(8'h00, 8'h80 | mw[i]);
      wait_load();
      chk(dsel, mw[i][3:2], "diode steering");
      x = expv(mw[i]);
      rd16(8'h04, v);
      chk(v, x[15:0], "reading");
      rd16(8'h06, v);
      chk(v, x[31:16], "timer");
    end
    u_host.wr(8'h00, 8'h8F);
    repeat (300) @(posedge clock_in);
    chk(integ, 0, "no-op mode");
    $display("test conversions done");
    u_host.wr(8'h02, 8'h00);
    for (i = 0; i < 4; i++) begin
      u_host.wr(8'h01, 8'(i));
      u_host.rd(8'h01, b);
      chk(b[5], 0, "flag write zero");
      u_host.wr(8'h00, 8'h00);
      u_host.wr(8'h00, 8'h83);
      for (j = 1; j <= pc[i]; j++) begin
        wait_load();
        chk(int_oe, 16'(j == pc[i]), "persist");
      end
      u_host.rd(8'h01, b);
      chk(b[5], 1, "flag set");
    end
    u_host.wr(8'h40, 8'h83);
    u_host.rd(8'h01, b);
    chk({b[5], int_oe, int_pin}, 0, "clear command");
    $display("test interrupt done");
    u_host.wr(8'h00, 8'hA3);
    u_host.wr(8'h80, 8'hA3);
    t0 = cyc;
    for (i = 0; i < 4; i++) begin
      r = lfsr(r);
      repeat (400 + r[8:0]) @(posedge clock_in);
      u_host.wr(8'h80, 8'hA3);
      e = 16'((cyc - t0) / 8);
      t0 = cyc;
      repeat (4) @(posedge clock_in);
      rd16(8'h06, v);
      chk(v > e + 2 || v + 2 < e, 0, "host period");
    end
    $display("test host timing done");
    test_done();
  end
endmodule
bind lsrc_core lsrc_core_sva u_sva (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .clk_en_in(clk_en_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .rd_data_out(rd_data_out), .int_pin_oe_out(int_pin_oe_out),
  .core_reset_out(core_reset_out), .converter_power_down_out(converter_power_down_out),
  .osc_fast_sel_out(osc_fast_sel_out), .range_sel_out(range_sel_out),
  .integrating_out(integrating_out));
`default_nettype wire
